// ---- hdl/stack_pkg.sv ----
// constants, types and helpers shared by the stack limit checker
//
// How it works
// (R01) stack pointer names first free word
// (R02) stack grows upward, shrinks downward
// (R03) pop decrements first, push increments after
// (R04) call pushes pc with clear upper byte
// (R05) exception pushes status low byte above pc
// (R06) stack limit has no reset value
// (R07) stack limit bit zero always zero
// (R08) every pointer address checked against limit
// (R09) push at limit passes, next traps
// (R10) address below special function area traps
// (R11) no pointer read right after limit write
// (R12) push above limit gives one trap request
package stack_pkg;

  // ---------------------------------------------
  // widths and fixed values
  // ---------------------------------------------
  localparam int WORD_W = 16;                        // data word width
  localparam int PC_W = 23;                          // program counter width
  localparam int PC_HI_LSB = 16;                     // first pc bit of high word
  localparam int HI_BYTE_LSB = 8;                    // upper byte of a word
  localparam logic [15:0] SP_STEP = 16'h0002;        // one word in bytes
  localparam logic [15:0] SP_RESET_VALUE = 16'h0800; // pointer after reset
  localparam logic [15:0] SFR_AREA_TOP = 16'h0800;   // special_function_area below
  localparam logic [7:0] ZERO_BYTE = 8'h00;          // cleared upper byte

  // ---------------------------------------------
  // enumerations
  // ---------------------------------------------
  typedef enum logic [1:0] {PUSH_DATA, PUSH_CALL, PUSH_EXCEPTION} push_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH_CHK, ST_PUSH_INC, ST_POP_CHK, ST_POP_RD, ST_POP_WAIT, ST_POP_DATA
  } state_t;

  // word alignment, used for pointer and limit writes
  function automatic logic [15:0] align_word(input logic [15:0] v);
    return {v[15:1], 1'b0};
  endfunction

endpackage

// ---- hdl/stack_frame_former.sv ----
// forms the one or two words that a push stores
`timescale 1ns/1ps
`default_nettype none
module stack_frame_former (
  input wire stack_pkg::push_kind_t i_kind,
  input wire logic [15:0] i_data,
  input wire logic [22:0] i_pc,
  input wire logic [7:0] i_status_low_byte,
  output logic [15:0] o_word_lo,
  output logic [15:0] o_word_hi,
  output logic o_two_words
);
  import stack_pkg::*;

  // ---------------------------------------------
  // word selection per push kind
  // ---------------------------------------------
  always_comb begin
    o_word_lo = i_data;
    o_word_hi = i_data;
    o_two_words = 1'b0;
    case (i_kind)
      PUSH_DATA: begin
        o_word_lo = i_data;
      end
      PUSH_CALL: begin
        o_word_lo = i_pc[PC_HI_LSB-1:0];
        o_word_hi = {ZERO_BYTE, 1'b0, i_pc[PC_W-1:PC_HI_LSB]}; // [R04]
        o_two_words = 1'b1;
      end
      PUSH_EXCEPTION: begin
        o_word_lo = i_pc[PC_HI_LSB-1:0];
        o_word_hi = {i_status_low_byte, 1'b0, i_pc[PC_W-1:PC_HI_LSB]}; // [R05]
        o_two_words = 1'b1;
      end
      default: begin
        o_two_words = 1'b0;
      end
    endcase
  end

endmodule // stack_frame_former
`default_nettype wire

// ---- hdl/stack_bound_check.sv ----
// compares one stack address against the limit and the low bound
`timescale 1ns/1ps
`default_nettype none
module stack_bound_check (
  input wire logic [15:0] i_ea,
  input wire logic [15:0] i_limit,
  input wire logic i_limit_known,
  output logic o_over,
  output logic o_under
);
  import stack_pkg::*;

  // ---------------------------------------------
  // bound comparison
  // ---------------------------------------------
  // equal to the limit is still legal, only above traps
  always_comb begin
    o_over = i_limit_known && (i_ea > i_limit); // [R09] [R12]
    o_under = i_ea < SFR_AREA_TOP;              // [R10]
  end

endmodule // stack_bound_check
`default_nettype wire

// ---- hdl/stack_limit_checker.sv ----
// software stack sequencer with limit and underflow trap detection
`timescale 1ns/1ps
`default_nettype none
module stack_limit_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_push_req,
  input wire stack_pkg::push_kind_t i_push_kind,
  input wire logic [15:0] i_push_data,
  input wire logic [22:0] i_pc,
  input wire logic [7:0] i_status_low_byte,
  input wire logic i_pop_req,
  input wire logic i_sp_wr,
  input wire logic [15:0] i_sp_data,
  input wire logic i_limit_wr,
  input wire logic [15:0] i_limit_data,
  input wire logic i_ea_valid,
  input wire logic [15:0] i_ea,
  input wire logic [15:0] i_mem_rdata,
  output logic [15:0] o_sp,
  output logic o_busy,
  output logic o_mem_wr,
  output logic o_mem_rd,
  output logic [15:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  output logic [15:0] o_pop_data,
  output logic o_done,
  output logic o_trap_req,
  output logic o_trap_overflow,
  output logic o_trap_underflow
);
  import stack_pkg::*;

  // ---------------------------------------------
  // state and storage
  // ---------------------------------------------
  state_t state_reg;             // sequencer state
  state_t state_next;            // its next value
  logic [15:0] stack_pointer_reg; // first free word
  logic [15:0] stack_limit_reg;  // upper bound, no reset
  logic limit_known_reg;         // limit written since reset
  push_kind_t kind_reg;          // kind of push in flight
  logic [15:0] word_lo_reg;      // first word to store
  logic [15:0] word_hi_reg;      // second word to store
  logic two_words_reg;           // push stores two words
  logic word_sel_reg;            // second word in progress
  logic [7:0] status_reg;        // status byte caught at start

  // ---------------------------------------------
  // combinational helpers
  // ---------------------------------------------
  logic start_push;              // push taken this cycle
  logic start_pop;               // pop taken this cycle
  logic [15:0] fsm_ea;           // address the sequencer checks
  logic fsm_over;                // sequencer address above limit
  logic fsm_under;               // sequencer address too low
  logic fsm_viol;                // either of the two
  logic in_check;                // a check state is active
  logic ext_over;                // outside address above limit
  logic ext_under;               // outside address too low
  logic [15:0] frame_lo;         // first word from the former
  logic [15:0] frame_hi;         // second word from the former
  logic frame_two;               // former wants two words

  // push wins when both arrive together
  assign start_push = (state_reg == ST_IDLE) && i_push_req;
  assign start_pop = (state_reg == ST_IDLE) && i_pop_req && !i_push_req;
  assign in_check = (state_reg == ST_PUSH_CHK) || (state_reg == ST_POP_CHK);
  assign fsm_viol = in_check && (fsm_over || fsm_under);
  assign o_sp = stack_pointer_reg;

  // push stores at the pointer, pop reads one word below it
  assign fsm_ea = (state_reg == ST_POP_CHK) ? (stack_pointer_reg - SP_STEP) // [R03]
                                            : stack_pointer_reg;           // [R01]

  // ---------------------------------------------
  // sub blocks
  // ---------------------------------------------
  stack_frame_former u_former (
    .i_kind(i_push_kind),
    .i_data(i_push_data),
    .i_pc(i_pc),
    .i_status_low_byte(i_status_low_byte),
    .o_word_lo(frame_lo),
    .o_word_hi(frame_hi),
    .o_two_words(frame_two)
  );

  // checks the address the sequencer is about to use
  stack_bound_check u_fsm_check (
    .i_ea(fsm_ea),
    .i_limit(stack_limit_reg),
    .i_limit_known(limit_known_reg),
    .o_over(fsm_over),
    .o_under(fsm_under)
  );

  // checks other pointer-based addresses from the core
  stack_bound_check u_ext_check (
    .i_ea(i_ea),
    .i_limit(stack_limit_reg),
    .i_limit_known(limit_known_reg),
    .o_over(ext_over),
    .o_under(ext_under)
  );

  // ---------------------------------------------
  // sequencer
  // ---------------------------------------------
  // next state, a trap ends the operation at once
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_push) begin
          state_next = ST_PUSH_CHK;
        end else if (start_pop) begin
          state_next = ST_POP_CHK;
        end
      end
      ST_PUSH_CHK: begin
        state_next = fsm_viol ? ST_IDLE : ST_PUSH_INC;
      end
      ST_PUSH_INC: begin
        // second word follows at the new pointer
        state_next = (two_words_reg && !word_sel_reg) ? ST_PUSH_CHK : ST_IDLE;
      end
      ST_POP_CHK: begin
        state_next = fsm_viol ? ST_IDLE : ST_POP_RD;
      end
      ST_POP_RD: begin
        state_next = ST_POP_WAIT;
      end
      ST_POP_WAIT: begin
        state_next = ST_POP_DATA;
      end
      ST_POP_DATA: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // state register and busy flag
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      o_busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      o_busy <= (state_next != ST_IDLE);
    end
  end

  // push frame capture at the moment a push is taken
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      kind_reg <= PUSH_DATA;
      word_lo_reg <= 16'h0000;
      word_hi_reg <= 16'h0000;
      two_words_reg <= 1'b0;
      status_reg <= 8'h00;
      word_sel_reg <= 1'b0;
    end else if (start_push) begin
      kind_reg <= i_push_kind;
      word_lo_reg <= frame_lo;
      word_hi_reg <= frame_hi;
      two_words_reg <= frame_two;
      status_reg <= i_status_low_byte;
      word_sel_reg <= 1'b0;
    end else if ((state_reg == ST_PUSH_INC) && two_words_reg) begin
      word_sel_reg <= 1'b1;
    end
  end

  // ---------------------------------------------
  // stack pointer
  // ---------------------------------------------
  // core writes are only taken while idle, so a write never races an update
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      stack_pointer_reg <= SP_RESET_VALUE;
    end else if (state_reg == ST_PUSH_INC) begin
      stack_pointer_reg <= stack_pointer_reg + SP_STEP; // [R02] [R03]
    end else if ((state_reg == ST_POP_CHK) && !fsm_viol) begin
      stack_pointer_reg <= stack_pointer_reg - SP_STEP; // [R02] [R03]
    end else if ((state_reg == ST_IDLE) && i_sp_wr && !start_push && !start_pop) begin
      stack_pointer_reg <= align_word(i_sp_data);
    end
  end

  // ---------------------------------------------
  // stack limit
  // ---------------------------------------------
  // left without reset on purpose; compares against it are held off until
  // the first write so an unset limit never raises a false trap
  always_ff @(posedge i_sys_clk) begin
    if (i_limit_wr) begin
      stack_limit_reg <= align_word(i_limit_data); // [R06] [R07]
    end
  end

  // a new limit counts from the next cycle; a check in the write cycle still
  // sees the old one, which is why software leaves a gap [R11]
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      limit_known_reg <= 1'b0;
    end else if (i_limit_wr) begin
      limit_known_reg <= 1'b1;
    end
  end

  // ---------------------------------------------
  // memory port
  // ---------------------------------------------
  // write goes out before the pointer moves, read after it moved
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_wr <= 1'b0;
      o_mem_rd <= 1'b0;
      o_mem_addr <= 16'h0000;
      o_mem_wdata <= 16'h0000;
    end else begin
      o_mem_wr <= (state_reg == ST_PUSH_CHK) && !fsm_viol; // [R03] [R08]
      o_mem_rd <= (state_reg == ST_POP_RD);                // [R03]
      if ((state_reg == ST_PUSH_CHK) || (state_reg == ST_POP_RD)) begin
        o_mem_addr <= stack_pointer_reg; // [R01]
      end
      if (state_reg == ST_PUSH_CHK) begin
        o_mem_wdata <= word_sel_reg ? word_hi_reg : word_lo_reg;
      end
    end
  end

  // pop data arrives one cycle after the read strobe
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pop_data <= 16'h0000;
      o_done <= 1'b0;
    end else begin
      if (state_reg == ST_POP_DATA) begin
        o_pop_data <= i_mem_rdata;
      end
      o_done <= (state_reg == ST_POP_DATA) ||
                ((state_reg == ST_PUSH_INC) && !(two_words_reg && !word_sel_reg));
    end
  end

  // ---------------------------------------------
  // trap request
  // ---------------------------------------------
  // one pulse per cycle with an offending address, cause bits pulse with it
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_trap_req <= 1'b0;
      o_trap_overflow <= 1'b0;
      o_trap_underflow <= 1'b0;
    end else begin
      o_trap_req <= fsm_viol || (i_ea_valid && (ext_over || ext_under)); // [R08] [R12]
      o_trap_overflow <= (in_check && fsm_over) || (i_ea_valid && ext_over); // [R09]
      o_trap_underflow <= (in_check && fsm_under) || (i_ea_valid && ext_under); // [R10]
    end
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  property p_push_at_pointer;
    @(posedge i_sys_clk) disable iff (i_rst)
    o_mem_wr |-> (o_mem_addr == o_sp);
  endproperty
  a_push_at_pointer: assert property (p_push_at_pointer) // [R01]
    else $error("push address is not the stack pointer");

  property p_push_then_inc;
    @(posedge i_sys_clk) disable iff (i_rst)
    o_mem_wr |=> (o_sp == $past(o_mem_addr) + SP_STEP);
  endproperty
  a_push_then_inc: assert property (p_push_then_inc) // [R02] [R03]
    else $error("pointer not raised by one word after push");

  property p_pop_dec_first;
    @(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_mem_rd) |-> (o_mem_addr == o_sp) && ($past(o_sp, 2) == o_sp + SP_STEP);
  endproperty
  a_pop_dec_first: assert property (p_pop_dec_first) // [R03]
    else $error("pop read not at the lowered pointer");

  property p_call_hi_clear;
    @(posedge i_sys_clk) disable iff (i_rst)
    (o_mem_wr && word_sel_reg && (kind_reg == PUSH_CALL)) |->
      (o_mem_wdata[WORD_W-1:HI_BYTE_LSB] == ZERO_BYTE) && !o_mem_wdata[HI_BYTE_LSB-1];
  endproperty
  a_call_hi_clear: assert property (p_call_hi_clear) // [R04]
    else $error("call push upper bits not clear");

  property p_exc_status;
    @(posedge i_sys_clk) disable iff (i_rst)
    (o_mem_wr && word_sel_reg && (kind_reg == PUSH_EXCEPTION)) |->
      (o_mem_wdata[WORD_W-1:HI_BYTE_LSB] == status_reg);
  endproperty
  a_exc_status: assert property (p_exc_status) // [R05]
    else $error("exception push lacks status byte");

  property p_limit_even;
    @(posedge i_sys_clk) disable iff (i_rst)
    limit_known_reg |-> !stack_limit_reg[0];
  endproperty
  a_limit_even: assert property (p_limit_even) // [R07]
    else $error("stack limit bit zero set");

  property p_at_limit_passes;
    @(posedge i_sys_clk) disable iff (i_rst)
    ((state_reg == ST_PUSH_CHK) && limit_known_reg && !i_ea_valid &&
     (stack_pointer_reg == stack_limit_reg) && !fsm_under) |=> (o_mem_wr && !o_trap_req);
  endproperty
  a_at_limit_passes: assert property (p_at_limit_passes) // [R09]
    else $error("push at the limit was trapped");

  property p_above_limit_traps;
    @(posedge i_sys_clk) disable iff (i_rst)
    ((state_reg == ST_PUSH_CHK) && limit_known_reg &&
     (stack_pointer_reg > stack_limit_reg)) |=> (o_trap_req && o_trap_overflow && !o_mem_wr)
      ##1 (!o_busy && (o_sp == $past(o_sp, 2)));
  endproperty
  a_above_limit_traps: assert property (p_above_limit_traps) // [R08] [R12]
    else $error("push above the limit not trapped");

  property p_low_address_traps;
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_ea_valid && (i_ea < SFR_AREA_TOP)) |=> (o_trap_req && o_trap_underflow);
  endproperty
  a_low_address_traps: assert property (p_low_address_traps) // [R10]
    else $error("low stack address not trapped");

endmodule // stack_limit_checker
`default_nettype wire

// ---- tb/stack_mem_model.sv ----
// data memory seen by the stack sequencer, behavioural
`timescale 1ns/1ps
`default_nettype none
module stack_mem_model (
  input wire logic i_clk,
  input wire logic i_mem_wr,
  input wire logic i_mem_rd,
  input wire logic [15:0] i_mem_addr,
  input wire logic [15:0] i_mem_wdata,
  output logic [15:0] o_mem_rdata
);
  // ---------------------------------------------
  // word storage
  // ---------------------------------------------
  logic [15:0] mem [0:32767]; // word index is addr[15:1]

  // blank memory so a suppressed write shows as zero
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    o_mem_rdata = 16'h0000;
  end

  // ---------------------------------------------
  // write and read port
  // ---------------------------------------------
  // read data lives for one cycle only; otherwise it toggles so a
  // late sample never lands on a stale but plausible word
  always @(posedge i_clk) begin
    if (i_mem_wr === 1'b1) begin
      mem[i_mem_addr[15:1]] <= i_mem_wdata;
    end
    if (i_mem_rd === 1'b1) begin
      o_mem_rdata <= mem[i_mem_addr[15:1]];
    end else begin
      o_mem_rdata <= ~o_mem_rdata;
    end
  end
endmodule // stack_mem_model
`default_nettype wire

// ---- tb/test_stack_limit_checker.sv ----
// self-checking bench for the stack limit checker
`timescale 1ns/1ps
`default_nettype none
module test_stack_limit_checker;
  import stack_pkg::*;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic clk, i_rst, i_push_req, i_pop_req, i_sp_wr, i_limit_wr, i_ea_valid;
  push_kind_t i_push_kind;
  logic [15:0] i_push_data, i_sp_data, i_limit_data, i_ea, i_mem_rdata;
  logic [22:0] i_pc;
  logic [7:0] i_status_low_byte;
  logic [15:0] o_sp, o_mem_addr, o_mem_wdata, o_pop_data;
  logic o_busy, o_mem_wr, o_mem_rd, o_done, o_trap_req, o_trap_overflow, o_trap_underflow;
  // expected result: trap bits, pointer, which word to compare
  typedef struct {logic t; logic o; logic u; logic [15:0] sp; logic [1:0] sel;
    logic [15:0] v;} exp_t;
  exp_t exp_q[$]; // oldest note first
  exp_t e;
  int err_count = 0;
  int n_tests = 0;
  logic [15:0] r, sp_e, hi;
  logic [15:0] d [0:3];
  logic [22:0] pc;
  logic [7:0] sl;
  push_kind_t kind;

  // ---------------------------------------------
  // design and far side
  // ---------------------------------------------
  stack_limit_checker uut (.i_sys_clk(clk), .i_rst(i_rst), .i_push_req(i_push_req),
    .i_push_kind(i_push_kind), .i_push_data(i_push_data), .i_pc(i_pc),
    .i_status_low_byte(i_status_low_byte), .i_pop_req(i_pop_req), .i_sp_wr(i_sp_wr),
    .i_sp_data(i_sp_data), .i_limit_wr(i_limit_wr), .i_limit_data(i_limit_data),
    .i_ea_valid(i_ea_valid), .i_ea(i_ea), .i_mem_rdata(i_mem_rdata), .o_sp(o_sp),
    .o_busy(o_busy), .o_mem_wr(o_mem_wr), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_pop_data(o_pop_data), .o_done(o_done),
    .o_trap_req(o_trap_req), .o_trap_overflow(o_trap_overflow),
    .o_trap_underflow(o_trap_underflow));
  stack_mem_model u_mem (.i_clk(clk), .i_mem_wr(o_mem_wr), .i_mem_rd(o_mem_rd),
    .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata));

  // 100 MHz clock
  always #5 clk = ~clk;

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic note(input logic t, input logic o, input logic u, input logic [15:0] sp,
                      input logic [1:0] sel, input logic [15:0] v);
    exp_q.push_back('{t, o, u, sp, sel, v});
  endtask

  // bounded wait for the sequencer to go idle
  task automatic wait_idle();
    int n;
    for (n = 0; n < 20 && o_busy !== 1'b0; n++) @(negedge clk);
    if (n == 20) begin
      err_count++;
      complete_run();
    end
  endtask

  task automatic do_push(input push_kind_t k, input logic [15:0] dv, input logic [22:0] p,
                         input logic [7:0] s);
    @(negedge clk);
    i_push_req = 1'b1;
    i_pop_req = 1'b1; // a pop raised with a push must be dropped
    i_push_kind = k;
    i_push_data = dv;
    i_pc = p;
    i_status_low_byte = s;
    @(negedge clk);
    {i_push_req, i_pop_req} = 2'b00;
    wait_idle();
  endtask

  task automatic do_pop();
    @(negedge clk);
    i_pop_req = 1'b1;
    @(negedge clk);
    i_pop_req = 1'b0;
    wait_idle();
  endtask

  // one idle cycle after the write before any pointer based access
  task automatic set_limit(input logic [15:0] v);
    @(negedge clk);
    i_limit_wr = 1'b1;
    i_limit_data = v;
    @(negedge clk);
    i_limit_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic set_sp(input logic [15:0] v);
    @(negedge clk);
    i_sp_wr = 1'b1;
    i_sp_data = v;
    @(negedge clk);
    i_sp_wr = 1'b0;
    @(negedge clk);
  endtask

  // outside pointer address; trap expected only when a cause is given
  task automatic ea_try(input logic [15:0] a, input logic o, input logic u);
    if (o | u) note(1'b1, o, u, sp_e, 2'h0, 16'h0000);
    @(negedge clk);
    i_ea_valid = 1'b1;
    i_ea = a;
    @(negedge clk);
    i_ea_valid = 1'b0;
    i_ea = ~a;
    repeat (3) @(negedge clk);
  endtask

  // ---------------------------------------------
  // result watcher: each done or trap takes the oldest note
  // ---------------------------------------------
  always @(negedge clk) begin
    if (i_rst === 1'b0 && (o_done === 1'b1 || o_trap_req === 1'b1)) begin
      if (exp_q.size() == 0) begin
        chk(16'h0001, 16'h0000); // no result was due here
      end else begin
        e = exp_q.pop_front();
        chk({13'h0000, o_trap_req, o_trap_overflow, o_trap_underflow},
            {13'h0000, e.t, e.o, e.u});
        chk(o_sp, e.sp);
        // last access: a push wrote one word below the new pointer, a pop read at it
        if (e.sel != 2'h0) chk(o_mem_addr, (e.sel == 2'h1) ? e.sp - 16'h0002 : e.sp);
        if (e.sel == 2'h1) chk(o_mem_wdata, e.v);
        if (e.sel == 2'h2) chk(o_pop_data, e.v);
      end
    end
  end

  // hang guard, far beyond the cycle count of the run
  initial begin
    #500000;
    err_count++;
    complete_run();
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    clk = 1'b0;
    i_rst = 1'b1;
    {i_push_req, i_pop_req, i_sp_wr, i_limit_wr, i_ea_valid} = 5'h00;
    i_push_kind = PUSH_DATA;
    {i_push_data, i_sp_data, i_limit_data, i_ea} = 64'h0;
    i_pc = 23'h000000;
    i_status_low_byte = 8'h00;
    r = 16'h44ff;
    repeat (5) @(negedge clk);
    i_rst = 1'b0;
    sp_e = 16'h0800;
    chk(o_sp, sp_e);
    // limit never written: no overflow yet
    for (int i = 0; i < 2; i++) begin
      r = lfsr_next(r);
      d[i] = r;
      sp_e = sp_e + 16'h0002;
      note(1'b0, 1'b0, 1'b0, sp_e, 2'h1, r);
      do_push(PUSH_DATA, r, 23'h000000, 8'h00);
    end
    // odd limit reads back even, so 0807 is above it
    set_limit(16'h0807);
    ea_try(16'h0807, 1'b1, 1'b0);
    ea_try(16'h0806, 1'b0, 1'b0);
    ea_try(16'h07fe, 1'b0, 1'b1);
    // fill up to and past the limit
    for (int i = 2; i < 4; i++) begin
      r = lfsr_next(r);
      d[i] = r;
      sp_e = sp_e + 16'h0002;
      note(1'b0, 1'b0, 1'b0, sp_e, 2'h1, r);
      do_push(PUSH_DATA, r, 23'h000000, 8'h00);
    end
    note(1'b1, 1'b1, 1'b0, sp_e, 2'h0, 16'h0000);
    do_push(PUSH_DATA, 16'hbeef, 23'h000000, 8'h00);
    chk(u_mem.mem[sp_e[15:1]], 16'h0000);
    // pops come back last in first out
    for (int i = 3; i >= 2; i--) begin
      sp_e = sp_e - 16'h0002;
      note(1'b0, 1'b0, 1'b0, sp_e, 2'h2, d[i]);
      do_pop();
    end
    // call and exception frames
    set_limit(16'h0ffe);
    for (int k = 0; k < 2; k++) begin
      r = lfsr_next(r);
      pc = {r[6:0], lfsr_next(r)};
      sl = r[15:8] ^ 8'h5a;
      kind = (k == 1) ? PUSH_EXCEPTION : PUSH_CALL;
      hi = {((k == 1) ? sl : 8'h00), 1'b0, pc[22:16]};
      note(1'b0, 1'b0, 1'b0, sp_e + 16'h0004, 2'h1, hi);
      do_push(kind, 16'h0000, pc, sl);
      chk(u_mem.mem[sp_e[15:1]], pc[15:0]);
      chk(u_mem.mem[sp_e[15:1] + 15'h0001], hi);
      sp_e = sp_e + 16'h0004;
    end
    // first word at the limit passes, second word traps
    set_limit(sp_e);
    note(1'b1, 1'b1, 1'b0, sp_e + 16'h0002, 2'h0, 16'h0000);
    do_push(PUSH_CALL, 16'h0000, 23'h7fffff, 8'h00);
    chk(u_mem.mem[sp_e[15:1]], 16'hffff);
    // underflow on pop and push
    set_sp(16'h0800);
    note(1'b1, 1'b0, 1'b1, 16'h0800, 2'h0, 16'h0000);
    do_pop();
    set_sp(16'h07fd);
    chk(o_sp, 16'h07fc);
    note(1'b1, 1'b0, 1'b1, 16'h07fc, 2'h0, 16'h0000);
    do_push(PUSH_DATA, 16'h1234, 23'h000000, 8'h00);
    repeat (3) @(negedge clk);
    chk(16'(exp_q.size()), 16'h0000);
    complete_run();
  end
endmodule // test_stack_limit_checker
`default_nettype wire
